// >>> logic/safety_fault_code_monitor.sv
/*
  Fault detection and fault code reporting for a safety controller.
  Compares safety outputs with their commanded state, supervises one
  dual-channel safety input for concurrency and simultaneity, keeps a
  sticky record of every fault code and presents the highest priority
  code with its message category and hint.
  Assumes all inputs synchronous to clk; sys_reset is the controller's
  system reset request, diag_clear the diagnostics acknowledge.
  SIMUL_LIMIT may be shortened in simulation; its default is 3 s.
  The shown code is the lowest set status bit, so output faults
  are shown ahead of input faults.
*/
`timescale 1ns/1ps
module safety_fault_code_monitor
  import fault_pkg::*;
#(
  parameter int NUM_OUT     = 2,
  parameter int SIMUL_LIMIT = SIMUL_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 sys_reset,
  input  wire logic                 diag_clear,
  input  wire logic [NUM_OUT-1:0]   out_cmd,
  input  wire logic [NUM_OUT-1:0]   out_sense,
  input  wire logic [NUM_OUT-1:0]   out_ext_volt,
  input  wire logic                 int_fault,
  input  wire logic [2:0]           int_fault_idx,
  input  wire logic                 seq_timing_err,
  input  wire logic                 chan_a,
  input  wire logic                 chan_b,
  input  wire logic [DEB_W-1:0]     deb_len,
  output logic [NUM_CODES-1:0]      fault_status,
  output logic                      fault_active,
  output logic                      fault_new,
  output logic [3:0]                fault_major,
  output logic [4:0]                fault_minor,
  output fault_msg_t                fault_msg,
  output fault_hint_t               fault_hint
);

  // Last timer value before the second channel counts as late; the
  // timer starts from zero on entry to WAIT
  localparam logic [SIMUL_CNT_W-1:0] SIMUL_LAST =
    SIMUL_CNT_W'(SIMUL_LIMIT - 1);

  // ---------------------------------------------------------------
  // Input debounce
  // ---------------------------------------------------------------
  // Both raw channels pass the filter before any pair decision
  chan_if chans ();

  // Channel 0 is chan_a, channel 1 is chan_b
  assign chans.raw     = {chan_b, chan_a};
  assign chans.deb_len = deb_len;

  // One filter for the pair keeps both channels on equal delay
  chan_debounce u_debounce (
    .clk   (clk),
    .rst_n (rst_n),
    .ch    (chans)
  );

  // Filtered levels, 1 = Run
  logic run_a;
  logic run_b;
  assign run_a = chans.clean[0];
  assign run_b = chans.clean[1];

  // ---------------------------------------------------------------
  // Dual-channel pair supervisor
  // ---------------------------------------------------------------
  // Pair state and the simultaneity timer
  pair_state_t            pair_reg;
  pair_state_t            pair_next;
  logic [SIMUL_CNT_W-1:0] timer_reg;
  logic [SIMUL_CNT_W-1:0] timer_next;
  logic                   conc_evt;
  logic                   simul_evt;

  // A faulted pair must see both channels at Stop before it may arm
  // again, which forces the operator to cycle the input
  always_comb begin
    pair_next  = pair_reg;
    timer_next = '0;
    conc_evt   = 1'b0;
    simul_evt  = 1'b0;
    case (pair_reg)
      PAIR_IDLE: begin
        if (run_a && run_b) begin
          pair_next = PAIR_RUN;
        end else if (run_a ^ run_b) begin
          pair_next = PAIR_WAIT;
        end
      end
      PAIR_WAIT: begin
        if (run_a && run_b) begin
          pair_next = PAIR_RUN;
        end else if (!run_a && !run_b) begin
          pair_next = PAIR_IDLE;
        end else if (timer_reg >= SIMUL_LAST) begin
          simul_evt = 1'b1;
          pair_next = PAIR_FAULT;
        end else begin
          timer_next = SIMUL_CNT_W'(timer_reg + 1'b1);
        end
      end
      PAIR_RUN: begin
        if (!run_a && !run_b) begin
          pair_next = PAIR_IDLE;
        end else if (run_a ^ run_b) begin
          pair_next = PAIR_DROP;
        end
      end
      PAIR_DROP: begin
        if (run_a && run_b) begin
          conc_evt  = 1'b1;
          pair_next = PAIR_FAULT;
        end else if (!run_a && !run_b) begin
          pair_next = PAIR_IDLE;
        end
      end
      // No new pair faults until both channels are back at Stop
      PAIR_FAULT: begin
        if (!run_a && !run_b) begin
          pair_next = PAIR_IDLE;
        end
      end
      default: pair_next = PAIR_IDLE;
    endcase
  end

  // Register pair state; the timer is held at zero outside WAIT
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pair_reg  <= PAIR_IDLE;
      timer_reg <= '0;
    end else begin
      pair_reg  <= pair_next;
      timer_reg <= timer_next;
    end
  end

  // ---------------------------------------------------------------
  // Fault events and status record
  // ---------------------------------------------------------------
  // Status record, shown descriptor and new-fault flag
  logic [NUM_CODES-1:0] status_reg;
  logic [NUM_CODES-1:0] status_next;
  logic [NUM_CODES-1:0] evt;
  logic [NUM_CODES-1:0] clr;
  logic                 new_next;
  fault_desc_t          desc_next;
  logic                 active_next;
  fault_desc_t          desc_reg;
  logic                 active_reg;
  logic                 new_reg;

  // Sticky bits: an event in the clearing cycle still sets its bit.
  // Code 1.10 ignores the diagnostics clear and yields only to a
  // system reset
  always_comb begin
    evt = '0;
    evt[BIT_OUT_ON]  = |(~out_cmd & out_sense);
    evt[BIT_OUT_EXT] = |(out_cmd & out_ext_volt);
    for (int i = 0; i < NUM_INT; i++) begin
      evt[BIT_INT_FIRST + i] = int_fault &&
                               (int_fault_idx == 3'(i));
    end
    evt[BIT_SEQ]   = seq_timing_err;
    evt[BIT_CONC]  = conc_evt;
    evt[BIT_SIMUL] = simul_evt;

    // Diagnostics clear spares code 1.10
    clr = {NUM_CODES{diag_clear | sys_reset}};
    clr[BIT_SEQ] = sys_reset;
    status_next = (status_reg & ~clr) | evt;
    new_next    = |(evt & ~status_reg);

    // Descriptor of the highest priority code still held
    active_next = |status_next;
    desc_next   = describe(first_set(status_next));
  end

  // Record and descriptor share one edge, so the shown code never
  // lags the status bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_reg <= STATUS_RESET;
      new_reg    <= 1'b0;
      active_reg <= 1'b0;
      desc_reg   <= '{4'h0, 5'h00, MSG_NONE, HINT_NONE};
    end else begin
      status_reg <= status_next;
      new_reg    <= new_next;
      active_reg <= active_next;
      desc_reg   <= desc_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  // Plain wires from the registers, no logic after the flops
  assign fault_status = status_reg;
  assign fault_active = active_reg;
  assign fault_new    = new_reg;
  assign fault_major  = desc_reg.major;
  assign fault_minor  = desc_reg.minor;
  assign fault_msg    = desc_reg.msg;
  assign fault_hint   = desc_reg.hint;

endmodule

// >>> logic/fault_pkg.sv
/*
  Shared constants, types and decode functions for the safety fault code
  monitor: fault code numbers, message categories, hints, timing counts.
  Assumes a single 20 MHz clock domain and a synthesis tool that accepts
  functions and packed structs in a package.
*/
package fault_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 20_000_000;
  localparam int SIMUL_TIME_S  = 3;                    // Second channel limit
  localparam int SIMUL_CYCLES  = SIMUL_TIME_S * CLK_HZ;
  localparam int SIMUL_CNT_W   = 26;                   // Holds SIMUL_CYCLES
  localparam int DEB_W         = 16;                   // Debounce count width

  // ---------------------------------------------------------------
  // Status record bit positions, one per fault code
  // ---------------------------------------------------------------
  localparam int NUM_CODES     = 11;
  localparam int BIT_OUT_ON    = 0;                    // Code 1.1
  localparam int BIT_OUT_EXT   = 1;                    // Code 1.2
  localparam int BIT_INT_FIRST = 2;                    // Codes 1.3 .. 1.8
  localparam int NUM_INT       = 6;
  localparam int BIT_SEQ       = 8;                    // Code 1.10
  localparam int BIT_CONC      = 9;                    // Code 2.1
  localparam int BIT_SIMUL     = 10;                   // Code 2.2
  localparam logic [NUM_CODES-1:0] STATUS_RESET = 11'h000;

  // ---------------------------------------------------------------
  // Code numbers as shown on the diagnostics view
  // ---------------------------------------------------------------
  localparam logic [3:0] MAJOR_OUTPUT = 4'h1;
  localparam logic [3:0] MAJOR_INPUT  = 4'h2;
  localparam logic [4:0] MINOR_OUT_ON = 5'h01;
  localparam logic [4:0] MINOR_EXT    = 5'h02;
  localparam logic [4:0] MINOR_INT0   = 5'h03;
  localparam logic [4:0] MINOR_SEQ    = 5'h0a;
  localparam logic [4:0] MINOR_CONC   = 5'h01;
  localparam logic [4:0] MINOR_SIMUL  = 5'h02;

  typedef enum logic [2:0] {
    MSG_NONE         = 3'h0,
    MSG_OUTPUT       = 3'h1,
    MSG_INTERNAL     = 3'h2,
    MSG_CONCURRENCY  = 3'h3,
    MSG_SIMULTANEITY = 3'h4
  } fault_msg_t;

  typedef enum logic [1:0] {
    HINT_NONE         = 2'h0,
    HINT_CHECK_SHORTS = 2'h1,
    HINT_INPUT_TIMING = 2'h2,
    HINT_CYCLE_INPUT  = 2'h3
  } fault_hint_t;

  typedef struct packed {
    logic [3:0]  major;
    logic [4:0]  minor;
    fault_msg_t  msg;
    fault_hint_t hint;
  } fault_desc_t;

  // Dual-channel pair supervisor, Gray coded along idle-wait-run-drop
  typedef enum logic [2:0] {
    PAIR_IDLE  = 3'b000,
    PAIR_WAIT  = 3'b001,
    PAIR_RUN   = 3'b011,
    PAIR_DROP  = 3'b010,
    PAIR_FAULT = 3'b110
  } pair_state_t;

  // Lowest set bit wins, so output faults outrank input faults
  function automatic logic [3:0] first_set(input logic [NUM_CODES-1:0] s);
    logic [3:0] idx;
    idx = 4'hf;
    for (int i = NUM_CODES - 1; i >= 0; i--) begin
      if (s[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Descriptor for one status bit
  function automatic fault_desc_t describe(input logic [3:0] idx);
    fault_desc_t d;
    d = '{major: 4'h0, minor: 5'h00, msg: MSG_NONE, hint: HINT_NONE};
    case (idx)
      4'h0: d = '{MAJOR_OUTPUT, MINOR_OUT_ON, MSG_OUTPUT, HINT_CHECK_SHORTS};
      4'h1: d = '{MAJOR_OUTPUT, MINOR_EXT, MSG_OUTPUT, HINT_CHECK_SHORTS};
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
        d = '{MAJOR_OUTPUT, 5'(MINOR_INT0 + 5'(idx) - 5'h02),
              MSG_INTERNAL, HINT_NONE};
      end
      4'h8: d = '{MAJOR_OUTPUT, MINOR_SEQ, MSG_OUTPUT, HINT_INPUT_TIMING};
      4'h9: d = '{MAJOR_INPUT, MINOR_CONC, MSG_CONCURRENCY, HINT_CYCLE_INPUT};
      4'ha: d = '{MAJOR_INPUT, MINOR_SIMUL, MSG_SIMULTANEITY,
                  HINT_CYCLE_INPUT};
      default: d = '{4'h0, 5'h00, MSG_NONE, HINT_NONE};
    endcase
    return d;
  endfunction

endpackage

// >>> logic/chan_if.sv
/*
  Carrier between the fault monitor and its input debouncer: the two raw
  channels of a dual-channel input, the user debounce length and the
  filtered levels. Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface chan_if;
  import fault_pkg::*;
  logic [1:0]       raw;
  logic [DEB_W-1:0] deb_len;
  logic [1:0]       clean;

  modport filter (input raw, input deb_len, output clean);
  modport user   (output raw, output deb_len, input clean);
endinterface

// >>> logic/chan_debounce.sv
/*
  Debounce filter for the two channels of a dual-channel safety input.
  A channel's filtered level follows the raw level only after the raw
  level has differed from it for deb_len + 1 consecutive cycles.
  Assumes raw inputs already synchronous to clk.
*/
`timescale 1ns/1ps
module chan_debounce
  import fault_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  chan_if.filter    ch
);

  logic [DEB_W-1:0] cnt_reg   [2];
  logic [DEB_W-1:0] cnt_next  [2];
  logic [1:0]       clean_reg;
  logic [1:0]       clean_next;

  // ---------------------------------------------------------------
  // Filter
  // ---------------------------------------------------------------
  // A glitch shorter than the length restarts the count, so a
  // bouncing contact never reaches the concurrency check
  always_comb begin
    clean_next = clean_reg;
    for (int i = 0; i < 2; i++) begin
      cnt_next[i] = '0;
      if (ch.raw[i] != clean_reg[i]) begin
        if (cnt_reg[i] >= ch.deb_len) begin
          clean_next[i] = ch.raw[i];
        end else begin
          cnt_next[i] = DEB_W'(cnt_reg[i] + 1'b1);
        end
      end
    end
  end

  // Register filter state; both channels start at Stop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clean_reg  <= 2'h0;
      cnt_reg[0] <= '0;
      cnt_reg[1] <= '0;
    end else begin
      clean_reg  <= clean_next;
      cnt_reg[0] <= cnt_next[0];
      cnt_reg[1] <= cnt_next[1];
    end
  end

  assign ch.clean = clean_reg;

endmodule

// >>> test/field_side.sv
/*
  Far side model: two output loads and one two-contact input device.
  Assumes the bench steers welds, shorts and contact timing by inputs.
*/
`timescale 1ns/1ps
module field_side #(
  parameter int NUM_OUT = 2
) (
  input  wire logic               clk,
  input  wire logic [NUM_OUT-1:0] out_cmd,
  input  wire logic [NUM_OUT-1:0] stuck_on,
  input  wire logic [NUM_OUT-1:0] short_ext,
  input  wire logic               run_req,
  input  wire logic [7:0]         lag,
  input  wire logic               drop_a,
  output logic [NUM_OUT-1:0]      out_sense,
  output logic [NUM_OUT-1:0]      out_ext_volt,
  output logic                    chan_a,
  output logic                    chan_b
);
  logic [7:0] wait_reg;

  // Load follows its command unless welded on or fed from outside
  assign out_sense    = out_cmd | stuck_on;
  assign out_ext_volt = out_cmd & short_ext;

  // A slow second contact is how a real device trips the time limit
  always_ff @(posedge clk) begin
    wait_reg <= run_req ? wait_reg + {7'h00, wait_reg != 8'hff} : 8'h00;
  end
  assign chan_a = run_req & ~drop_a;
  assign chan_b = run_req & (wait_reg >= lag);
endmodule

// >>> test/monitor_assertions.sv
/*
  Port checker for the fault code monitor.
  Assumes one clock and a bind onto the monitor's top module.
*/
`timescale 1ns/1ps
module monitor_checker
  import fault_pkg::*;
#(
  parameter int NUM_OUT     = 2,
  parameter int SIMUL_LIMIT = SIMUL_CYCLES
) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               sys_reset,
  input wire logic               diag_clear,
  input wire logic [NUM_OUT-1:0] out_cmd,
  input wire logic [NUM_OUT-1:0] out_sense,
  input wire logic [NUM_OUT-1:0] out_ext_volt,
  input wire logic               int_fault,
  input wire logic [2:0]         int_fault_idx,
  input wire logic               seq_timing_err,
  input wire logic               chan_a,
  input wire logic               chan_b,
  input wire logic [10:0]        fault_status,
  input wire logic               fault_active,
  input wire logic               fault_new,
  input wire fault_msg_t         fault_msg,
  input wire fault_hint_t        fault_hint
);
  logic [SIMUL_CNT_W-1:0] split_reg;
  logic [SIMUL_CNT_W-1:0] split_next;

  // Raw channel disagreement run, saturating so it never wraps,
  // wide enough for the full 3 s limit
  always_comb begin
    split_next = '0;
    if (chan_a ^ chan_b) begin
      split_next = SIMUL_CNT_W'(split_reg + 1'b1);
      if (&split_reg) begin
        split_next = split_reg;
      end
    end
  end

  // Register the run length; reset empties it
  always_ff @(posedge clk) begin
    split_reg <= rst_n ? split_next : '0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  out_on_a: assert property (
    |(~out_cmd & out_sense) |=> fault_status[0])
    else $error("output on while off left unflagged");
  ext_volt_a: assert property (
    |(out_cmd & out_ext_volt) |=> fault_status[1])
    else $error("external source left unflagged");
  int_code_a: assert property (
    int_fault && int_fault_idx < 3'h6
    |=> fault_status[$past(int_fault_idx) + 2])
    else $error("internal fault code not recorded");
  int_msg_a: assert property (
    fault_status[1:0] == 2'b00 && |fault_status[7:2]
    |-> fault_msg == MSG_INTERNAL && fault_hint == HINT_NONE)
    else $error("internal fault shown with wrong message");
  seq_latch_a: assert property (
    (seq_timing_err || fault_status[8]) && !sys_reset |=> fault_status[8])
    else $error("sequence fault lost without system reset");
  sticky_rec_a: assert property (
    !diag_clear && !sys_reset
    |=> (fault_status & $past(fault_status)) == $past(fault_status))
    else $error("status bit dropped without a clear");
  active_flag_a: assert property (
    fault_active == (fault_status != 11'h000))
    else $error("active flag disagrees with status");
  new_pulse_a: assert property (
    $rose(fault_active) |-> fault_new)
    else $error("first fault gave no new pulse");
  simul_wait_a: assert property (
    $rose(fault_status[10]) |-> split_reg >= SIMUL_LIMIT)
    else $error("simultaneity fault raised too early");
  conc_msg_a: assert property (
    fault_status[8:0] == 9'h000 && fault_status[9]
    |-> fault_msg == MSG_CONCURRENCY && fault_hint == HINT_CYCLE_INPUT)
    else $error("concurrency fault shown with wrong message");

  conc_seen_c: cover property ($rose(fault_status[9]));
  simul_seen_c: cover property ($rose(fault_status[10]));
  seq_seen_c: cover property ($rose(fault_status[8]));
endmodule

bind safety_fault_code_monitor monitor_checker #(
  .NUM_OUT(NUM_OUT), .SIMUL_LIMIT(SIMUL_LIMIT)) chk_i (
  .clk(clk), .rst_n(rst_n), .sys_reset(sys_reset),
  .diag_clear(diag_clear), .out_cmd(out_cmd), .out_sense(out_sense),
  .out_ext_volt(out_ext_volt), .int_fault(int_fault),
  .int_fault_idx(int_fault_idx), .seq_timing_err(seq_timing_err),
  .chan_a(chan_a), .chan_b(chan_b), .fault_status(fault_status),
  .fault_active(fault_active), .fault_new(fault_new),
  .fault_msg(fault_msg), .fault_hint(fault_hint));

// >>> test/tb.sv
/*
  Self-checking bench for the fault code monitor and its far side.
  Assumes the checker binds itself; short simultaneity limit of 20.
*/
`timescale 1ns/1ps
module tb;
  import fault_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, sys_reset = 1'b0;
  logic        diag_clear = 1'b0, int_fault = 1'b0, seq_err = 1'b0;
  logic        run_req = 1'b0, drop_a = 1'b0, chan_a, chan_b;
  logic [1:0]  out_cmd = 2'h0, stuck_on = 2'h0, short_ext = 2'h0;
  logic [1:0]  out_sense, out_ext_volt;
  logic [2:0]  int_idx = 3'h0;
  logic [7:0]  lag = 8'h00;
  logic [15:0] deb_len = 16'h0000;
  logic [10:0] status, e;
  logic [3:0]  major;
  logic [4:0]  minor;
  logic        active, fnew;
  fault_msg_t  msg;
  fault_hint_t hint;
  int          num_errors = 0, compares = 0, cycles = 0;

  safety_fault_code_monitor #(.NUM_OUT(2), .SIMUL_LIMIT(20)) dut (
    .clk(clk), .rst_n(rst_n), .sys_reset(sys_reset),
    .diag_clear(diag_clear), .out_cmd(out_cmd), .out_sense(out_sense),
    .out_ext_volt(out_ext_volt), .int_fault(int_fault),
    .int_fault_idx(int_idx), .seq_timing_err(seq_err), .chan_a(chan_a),
    .chan_b(chan_b), .deb_len(deb_len), .fault_status(status),
    .fault_active(active), .fault_new(fnew), .fault_major(major),
    .fault_minor(minor), .fault_msg(msg), .fault_hint(hint));
  field_side #(.NUM_OUT(2)) far (
    .clk(clk), .out_cmd(out_cmd), .stuck_on(stuck_on),
    .short_ext(short_ext), .run_req(run_req), .lag(lag),
    .drop_a(drop_a), .out_sense(out_sense), .out_ext_volt(out_ext_volt),
    .chan_a(chan_a), .chan_b(chan_b));

  always #25 clk = ~clk;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Shown code: lowest set bit wins
  function automatic logic [13:0] exp_desc(input logic [10:0] s);
    logic [13:0] d;
    d = 14'h0000;
    if (s[10]) d = {4'h2, 5'h02, 3'h4, 2'h3};
    if (s[9]) d = {4'h2, 5'h01, 3'h3, 2'h3};
    if (s[8]) d = {4'h1, 5'h0a, 3'h1, 2'h2};
    for (int i = 7; i >= 2; i--) begin
      if (s[i]) d = {4'h1, 5'(i + 1), 3'h2, 2'h0};
    end
    if (s[1]) d = {4'h1, 5'h02, 3'h1, 2'h1};
    if (s[0]) d = {4'h1, 5'h01, 3'h1, 2'h1};
    return d;
  endfunction

  task automatic look(input logic [10:0] s);
    chk(status, s);
    chk(active, s != 11'h000);
    chk({major, minor, msg, hint}, exp_desc(s));
  endtask

  // One pass of the input pair, then stop both and clear to re-arm
  task automatic pair(input logic [15:0] dl, input logic [7:0] lg,
                      input int gap, input logic [10:0] s);
    @(posedge clk);
    deb_len <= dl;
    lag <= lg;
    run_req <= 1'b1;
    repeat (30) @(posedge clk);
    if (gap > 0) begin
      drop_a <= 1'b1;
      repeat (gap) @(posedge clk);
      drop_a <= 1'b0;
    end
    tick(30);
    look(s);
    @(posedge clk);
    run_req <= 1'b0;
    diag_clear <= 1'b1;
    tick(20);
    @(posedge clk);
    diag_clear <= 1'b0;
  endtask

  initial begin
    void'($urandom(73246));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    look(11'h000);
    // Random output and internal events; clear each cycle, event wins
    repeat (40) begin
      @(posedge clk);
      out_cmd <= 2'($urandom);
      stuck_on <= 2'($urandom & $urandom);
      short_ext <= 2'($urandom & $urandom);
      int_fault <= 1'($urandom);
      int_idx <= 3'($urandom);
      diag_clear <= 1'b1;
      tick(1);
      e = 11'h000;
      e[0] = |(~out_cmd & stuck_on);
      e[1] = |(out_cmd & short_ext);
      if (int_fault && int_idx < 3'h6) e[int_idx + 2] = 1'b1;
      look(e);
    end
    @(posedge clk);
    {stuck_on, short_ext, int_fault} <= 5'h00;
    @(posedge clk);
    diag_clear <= 1'b0;
    out_cmd <= 2'b01;
    stuck_on <= 2'b10;
    tick(1);
    chk(fnew, 1'b1);
    @(posedge clk);
    stuck_on <= 2'b00;
    tick(4);
    look(11'h001);
    chk(fnew, 1'b0);
    @(posedge clk);
    seq_err <= 1'b1;
    @(posedge clk);
    seq_err <= 1'b0;
    diag_clear <= 1'b1;
    tick(3);
    look(11'h100);
    @(posedge clk);
    diag_clear <= 1'b0;
    sys_reset <= 1'b1;
    @(posedge clk);
    sys_reset <= 1'b0;
    tick(1);
    look(11'h000);
    pair(16'h0000, 8'h00, 1, 11'h200);
    pair(16'h0003, 8'h00, 2, 11'h000);
    pair(16'h0003, 8'h00, 6, 11'h200);
    pair(16'h0000, 8'd24, 0, 11'h400);
    pair(16'h0000, 8'd17, 0, 11'h000);
    conclude();
  end
endmodule
